// *** hdl/usa_pkg.sv ***
// Constants, field layout and carrier types for the auto-baud and synchronous master transmit serial unit.
// Assumes an APB master on pclk and a data pin sampled synchronously to pclk.
package usa_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_TRANSMIT_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_RECEIVE_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_BAUD_CONTROL = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_RATE_LOW = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_RATE_HIGH = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_TRANSMIT_DATA = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_RECEIVE_DATA = 8'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int TS_SYNC = 0, TS_MASTER = 1, TS_TRANSMIT_ENABLE = 2, TS_NINE = 3, TS_NINTH = 4, TS_HSPEED = 5;
   localparam int TS_SHIFT_EMPTY = 6, TS_HOLD_EMPTY = 7;
   localparam int RS_PORT_EN = 0, RS_SINGLE_RX = 1, RS_CONT_RX = 2;
   localparam int BC_ABD_EN = 0, BC_WAKE = 1, BC_POL = 2, BC_WIDE = 3, BC_RX_FLAG = 4, BC_ABD_BUSY = 5;

   // ----------------------------------------------------------------
   // Auto-baud and shifting counts
   // ----------------------------------------------------------------
   localparam int BASE_DIV_SLOW = 64;
   localparam int BASE_DIV_MID = 16;
   localparam int BASE_DIV_FAST = 4;
   localparam int ABD_PER_BASE = 8;
   localparam logic [8:0] ABD_DIV_M1_SLOW = 9'(BASE_DIV_SLOW * ABD_PER_BASE - 1);
   localparam logic [8:0] ABD_DIV_M1_MID = 9'(BASE_DIV_MID * ABD_PER_BASE - 1);
   localparam logic [8:0] ABD_DIV_M1_FAST = 9'(BASE_DIV_FAST * ABD_PER_BASE - 1);
   localparam int ABD_RISE_EDGES = 5;
   localparam logic [2:0] ABD_LAST_EDGE = 3'(ABD_RISE_EDGES - 1);
   localparam logic [15:0] ABD_COUNT_START = 16'h0001;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [7:0] RX_DATA_IDLE = 8'h00;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_LEAD = 3'b010,
      TX_TRAIL = 3'b100
   } usa_tx_state_t;

   typedef enum logic [4:0] {
      AB_IDLE = 5'b00001,
      AB_BREAK = 5'b00010,
      AB_START = 5'b00100,
      AB_FIRST = 5'b01000,
      AB_COUNT = 5'b10000
   } usa_ab_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } usa_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
   } usa_apb_rsp_t;

   typedef struct packed {
      logic tx_clock_pin_o;
      logic tx_clock_pin_oe;
      logic rx_data_pin_o;
      logic rx_data_pin_oe;
   } usa_pins_t;

   typedef struct packed {
      usa_apb_rsp_t rsp;
      usa_pins_t pins;
      logic sync_mode;
      logic clock_source_master;
      logic transmit_enable;
      logic nine_bit_transmit;
      logic ninth_transmit_bit;
      logic high_speed_rate_select;
      logic serial_port_enable;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic auto_baud_enable;
      logic wake_on_break_enable;
      logic clock_polarity_select;
      logic wide_rate_gen_select;
      logic receive_flag;
      logic [7:0] rate_gen_low_byte;
      logic [7:0] rate_gen_high_byte;
      logic [8:0] tx_hold;
      logic tx_hold_full;
      logic [8:0] transmit_shift_reg;
      logic [3:0] bits_left;
      usa_tx_state_t tx_state;
      logic [16:0] half_cnt;
      usa_ab_state_t ab_state;
      logic [8:0] pre_cnt;
      logic [2:0] edges;
      logic rx_prev;
   } usa_state_t;
endpackage : usa_pkg

// *** hdl/usa_serial_unit.sv ***
// Serial unit: auto-baud measurement and synchronous master transmit, APB register slave.
// Assumes an APB master on pclk and a data pin input already synchronous to pclk.
module usa_serial_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire usa_pkg::usa_apb_req_t apb_req,
   output usa_pkg::usa_apb_rsp_t apb_rsp,
   input wire logic rx_data_pin_i,
   output usa_pkg::usa_pins_t pins
);
   import usa_pkg::*;

   usa_state_t s;
   usa_state_t next_s;

   assign apb_rsp = s.rsp;
   assign pins = s.pins;

   // ----------------------------------------------------------------
   // Combinational next state
   // ----------------------------------------------------------------
   logic setup_phase;
   logic access_done;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [DATA_W-1:0] rd_data;
   logic master_tx;
   logic idle_lvl;
   logic [16:0] half_end;
   logic half_last;
   logic start_char;
   logic [8:0] abd_div_m1;
   logic rise;
   logic fall;
   logic [15:0] abd_cnt;

   always_comb begin
      next_s = s;
      setup_phase = apb_req.psel && !apb_req.penable;
      access_done = apb_req.psel && apb_req.penable && s.rsp.pready;
      wr_en = access_done && apb_req.pwrite && !s.rsp.pslverr;
      rd_en = access_done && !apb_req.pwrite && !s.rsp.pslverr;
      start_char = 1'b0;

      // Read mux, looked up in the setup cycle so prdata is a flop in the access cycle
      hit = 1'b1;
      rd_data = '0;
      case (apb_req.paddr)
         OFF_TRANSMIT_STATUS: begin
            rd_data[TS_SYNC] = s.sync_mode;
            rd_data[TS_MASTER] = s.clock_source_master;
            rd_data[TS_TRANSMIT_ENABLE] = s.transmit_enable;
            rd_data[TS_NINE] = s.nine_bit_transmit;
            rd_data[TS_NINTH] = s.ninth_transmit_bit;
            rd_data[TS_HSPEED] = s.high_speed_rate_select;
            rd_data[TS_SHIFT_EMPTY] = (s.tx_state == TX_IDLE);
            rd_data[TS_HOLD_EMPTY] = !s.tx_hold_full;
         end
         OFF_RECEIVE_STATUS: begin
            rd_data[RS_PORT_EN] = s.serial_port_enable;
            rd_data[RS_SINGLE_RX] = s.single_receive_enable;
            rd_data[RS_CONT_RX] = s.continuous_receive_enable;
         end
         OFF_BAUD_CONTROL: begin
            rd_data[BC_ABD_EN] = s.auto_baud_enable;
            rd_data[BC_WAKE] = s.wake_on_break_enable;
            rd_data[BC_POL] = s.clock_polarity_select;
            rd_data[BC_WIDE] = s.wide_rate_gen_select;
            rd_data[BC_RX_FLAG] = s.receive_flag;
            rd_data[BC_ABD_BUSY] = (s.ab_state != AB_IDLE);
         end
         OFF_RATE_LOW: rd_data[7:0] = s.rate_gen_low_byte;
         OFF_RATE_HIGH: rd_data[7:0] = s.rate_gen_high_byte;
         // The shifter has no address; the data register reads as zero
         OFF_TRANSMIT_DATA: rd_data = '0;
         OFF_RECEIVE_DATA: rd_data[7:0] = RX_DATA_IDLE;
         default: hit = 1'b0;
      endcase

      // Zero wait states: pready is high in every access cycle
      next_s.rsp.pready = setup_phase;
      // The error flag stands only with pready, so it drops once the access ends
      if (setup_phase) begin
         next_s.rsp.pslverr = !hit;
         next_s.rsp.prdata = hit ? rd_data : '0;
      end else begin
         next_s.rsp.pslverr = 1'b0;
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (wr_en) begin
         case (apb_req.paddr)
            OFF_TRANSMIT_STATUS: begin
               next_s.sync_mode = apb_req.pwdata[TS_SYNC];
               next_s.clock_source_master = apb_req.pwdata[TS_MASTER];
               next_s.transmit_enable = apb_req.pwdata[TS_TRANSMIT_ENABLE];
               next_s.nine_bit_transmit = apb_req.pwdata[TS_NINE];
               next_s.ninth_transmit_bit = apb_req.pwdata[TS_NINTH];
               next_s.high_speed_rate_select = apb_req.pwdata[TS_HSPEED];
            end
            OFF_RECEIVE_STATUS: begin
               next_s.serial_port_enable = apb_req.pwdata[RS_PORT_EN];
               next_s.single_receive_enable = apb_req.pwdata[RS_SINGLE_RX];
               next_s.continuous_receive_enable = apb_req.pwdata[RS_CONT_RX];
            end
            OFF_BAUD_CONTROL: begin
               next_s.auto_baud_enable = apb_req.pwdata[BC_ABD_EN];
               next_s.wake_on_break_enable = apb_req.pwdata[BC_WAKE];
               next_s.clock_polarity_select = apb_req.pwdata[BC_POL];
               next_s.wide_rate_gen_select = apb_req.pwdata[BC_WIDE];
            end
            OFF_RATE_LOW: next_s.rate_gen_low_byte = apb_req.pwdata[7:0];
            OFF_RATE_HIGH: next_s.rate_gen_high_byte = apb_req.pwdata[7:0];
            OFF_TRANSMIT_DATA: begin
               // A write to a full holding register is dropped, not merged
               if (!s.tx_hold_full) begin
                  next_s.tx_hold = {s.ninth_transmit_bit, apb_req.pwdata[7:0]};
                  next_s.tx_hold_full = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // Reading the receive data register clears the flag
      if (rd_en && apb_req.paddr == OFF_RECEIVE_DATA) begin
         next_s.receive_flag = 1'b0;
      end

      // ----------------------------------------------------------------
      // Auto-baud measurement
      // ----------------------------------------------------------------
      rise = rx_data_pin_i && !s.rx_prev;
      fall = !rx_data_pin_i && s.rx_prev;
      next_s.rx_prev = rx_data_pin_i;
      case ({s.wide_rate_gen_select, s.high_speed_rate_select})
         2'b00: abd_div_m1 = ABD_DIV_M1_SLOW;
         2'b11: abd_div_m1 = ABD_DIV_M1_FAST;
         default: abd_div_m1 = ABD_DIV_M1_MID;
      endcase
      abd_cnt = {s.rate_gen_high_byte, s.rate_gen_low_byte};

      // No receiver lives here, so holding it idle costs nothing
      case (s.ab_state)
         AB_IDLE: begin
            if (s.auto_baud_enable) begin
               next_s.ab_state = s.wake_on_break_enable ? AB_BREAK : AB_START;
            end
         end
         AB_BREAK: begin
            // The break ends on its closing rising edge
            if (rise) begin
               next_s.ab_state = AB_START;
            end
         end
         AB_START: begin
            if (fall) begin
               next_s.ab_state = AB_FIRST;
            end
         end
         AB_FIRST: begin
            if (rise) begin
               next_s.ab_state = AB_COUNT;
               {next_s.rate_gen_high_byte, next_s.rate_gen_low_byte} = ABD_COUNT_START;
               next_s.pre_cnt = '0;
               next_s.edges = 3'h1;
            end
         end
         AB_COUNT: begin
            // Prescaled pclk clocks the measurement; the sync character's rising edges end it
            if (s.pre_cnt == abd_div_m1) begin
               next_s.pre_cnt = '0;
               {next_s.rate_gen_high_byte, next_s.rate_gen_low_byte} = abd_cnt + 16'h0001;
            end else begin
               next_s.pre_cnt = s.pre_cnt + 9'h001;
            end
            if (rise) begin
               if (s.edges == ABD_LAST_EDGE) begin
                  next_s.ab_state = AB_IDLE;
                  next_s.auto_baud_enable = 1'b0;
                  next_s.receive_flag = 1'b1;
               end else begin
                  next_s.edges = s.edges + 3'h1;
               end
            end
         end
         default: next_s.ab_state = AB_IDLE;
      endcase
      // Software dropping the enable abandons a measurement in progress
      if (!s.auto_baud_enable && s.ab_state != AB_IDLE) begin
         next_s.ab_state = AB_IDLE;
      end

      // ----------------------------------------------------------------
      // Synchronous master transmit
      // ----------------------------------------------------------------
      // Relies on software having set up master transmit
      master_tx = s.serial_port_enable && s.sync_mode && s.clock_source_master && s.transmit_enable
                  && !s.single_receive_enable && !s.continuous_receive_enable;
      idle_lvl = s.clock_polarity_select;
      next_s.pins.tx_clock_pin_oe = s.serial_port_enable && s.sync_mode && s.clock_source_master;
      next_s.pins.rx_data_pin_oe = master_tx;
      // Half a clock period is 2*(n+1) pclk cycles, so one bit is 4*(n+1)
      half_end = s.wide_rate_gen_select ? {abd_cnt, 1'b1} : {8'h00, s.rate_gen_low_byte, 1'b1};
      half_last = (s.half_cnt == half_end);
      next_s.half_cnt = half_last ? '0 : s.half_cnt + 17'h00001;

      case (s.tx_state)
         TX_IDLE: begin
            next_s.pins.tx_clock_pin_o = idle_lvl;
            next_s.half_cnt = '0;
            start_char = s.tx_hold_full;
         end
         TX_LEAD: begin
            if (half_last) begin
               next_s.pins.tx_clock_pin_o = idle_lvl;
               next_s.transmit_shift_reg = {1'b0, s.transmit_shift_reg[8:1]};
               next_s.bits_left = s.bits_left - 4'h1;
               next_s.tx_state = TX_TRAIL;
            end
         end
         TX_TRAIL: begin
            if (half_last) begin
               if (s.bits_left != 4'h0) begin
                  next_s.pins.tx_clock_pin_o = !idle_lvl;
                  next_s.pins.rx_data_pin_o = s.transmit_shift_reg[0];
                  next_s.tx_state = TX_LEAD;
               end else begin
                  // Last bit done: clock already idle, nothing more unless a character waits
                  next_s.tx_state = TX_IDLE;
                  start_char = s.tx_hold_full;
               end
            end
         end
         default: next_s.tx_state = TX_IDLE;
      endcase

      if (start_char && master_tx) begin
         next_s.transmit_shift_reg = s.tx_hold;
         next_s.bits_left = s.nine_bit_transmit ? BITS_NINE : BITS_EIGHT;
         next_s.tx_hold_full = wr_en && apb_req.paddr == OFF_TRANSMIT_DATA && !s.tx_hold_full;
         next_s.half_cnt = '0;
         next_s.pins.tx_clock_pin_o = !idle_lvl;
         next_s.pins.rx_data_pin_o = s.tx_hold[0];
         next_s.tx_state = TX_LEAD;
      end
      // Leaving master transmit aborts the character and parks the clock
      if (!master_tx && s.tx_state != TX_IDLE) begin
         next_s.tx_state = TX_IDLE;
         next_s.pins.tx_clock_pin_o = idle_lvl;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.tx_state <= TX_IDLE;
         s.ab_state <= AB_IDLE;
      end else if (ce) begin
         s <= next_s;
      end
   end
endmodule : usa_serial_unit

// *** testbench/usa_serial_unit_sva.sv ***
// Checker for the serial unit: bus answer, shift clock and data pin timing.
// Sees only the top module ports; bound to every instance below.
module usa_serial_unit_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire usa_pkg::usa_apb_req_t apb_req,
   input wire usa_pkg::usa_apb_rsp_t apb_rsp,
   input wire logic rx_data_pin_i,
   input wire usa_pkg::usa_pins_t pins
);
   import usa_pkg::*;
   // ----
   // Cycles since the shift clock last moved
   // ----
   logic clk_q;
   logic [7:0] quiet;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_q <= 1'b0;
         quiet <= 8'h00;
      end else begin
         clk_q <= pins.tx_clock_pin_o;
         if (pins.tx_clock_pin_o != clk_q) begin
            quiet <= 8'h00;
         end else if (quiet != 8'hff) begin
            quiet <= quiet + 8'h01;
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence s_tx_write;
      apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == OFF_TRANSMIT_DATA;
   endsequence
   property p_answer; s_setup |=> apb_rsp.pready; endproperty
   property p_ready_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
   property p_no_stray; apb_rsp.pready |-> apb_req.psel && apb_req.penable; endproperty
   property p_err_zero; apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == '0; endproperty
   property p_reset_idle; $rose(presetn) |-> pins == '0; endproperty
   property p_half_min;
      $changed(pins.tx_clock_pin_o) && pins.tx_clock_pin_oe |=> $stable(pins.tx_clock_pin_o);
   endproperty
   property p_data_lead;
      $changed(pins.rx_data_pin_o) && pins.rx_data_pin_oe && $past(pins.rx_data_pin_oe)
         |-> $changed(pins.tx_clock_pin_o);
   endproperty
   property p_oe_pair; pins.rx_data_pin_oe |-> pins.tx_clock_pin_oe; endproperty
   // Only a write into an idle shifter may start at once
   property p_start;
      s_tx_write ##0 (quiet >= 8'd16 && pins.rx_data_pin_oe) |-> ##[1:3] $changed(pins.tx_clock_pin_o);
   endproperty
   a_answer: assert property (p_answer) else $error("no bus answer after setup");
   a_ready_one: assert property (p_ready_one) else $error("ready held two cycles");
   a_no_stray: assert property (p_no_stray) else $error("ready outside access");
   a_err_zero: assert property (p_err_zero) else $error("error answer not clean");
   a_reset_idle: assert property (p_reset_idle) else $error("pins busy after reset");
   a_half_min: assert property (p_half_min) else $error("clock half too short");
   a_data_lead: assert property (p_data_lead) else $error("data moved without clock edge");
   a_oe_pair: assert property (p_oe_pair) else $error("data driven without clock");
   a_start: assert property (p_start) else $error("shifting did not start");
endmodule : usa_serial_unit_sva

bind usa_serial_unit usa_serial_unit_sva chk_u (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .rx_data_pin_i(rx_data_pin_i), .pins(pins));

// *** testbench/usa_slave_model.sv ***
// Far side: sender of the sync character, and a synchronous slave
// that samples the data pin on every trailing clock edge.
module usa_slave_model (
   input wire logic pclk,
   input wire usa_pkg::usa_pins_t pins,
   input wire logic pol,
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   import usa_pkg::*;
   logic [31:0] got = '0;
   int n_bits = 0;
   int n_lead = 0;
   logic clk_q = 1'b0;
   // Line is pulled up while nobody sends
   initial line = 1'b1;
   always @(posedge pclk) begin
      clk_q <= pins.tx_clock_pin_o;
      if (pins.tx_clock_pin_oe && clk_q == pol && pins.tx_clock_pin_o != pol) begin
         n_lead <= n_lead + 1;
      end
      if (pins.tx_clock_pin_oe && clk_q != pol && pins.tx_clock_pin_o == pol) begin
         got[n_bits] <= pins.rx_data_pin_o;
         n_bits <= n_bits + 1;
      end
   end
   task automatic clear();
      got = '0;
      n_bits = 0;
      n_lead = 0;
   endtask : clear
   task automatic send(input int bt, input bit brk);
      logic [9:0] frame;
      frame = {1'b1, 8'h55, 1'b0};
      // Stay idle until the unit has left its idle state, or the start bit fall is missed
      repeat (4) @(posedge pclk);
      if (brk) begin
         line <= 1'b0;
         repeat (13 * bt) @(posedge pclk);
         line <= 1'b1;
         repeat (bt) @(posedge pclk);
      end
      for (int i = 0; i < 10; i++) begin
         line <= frame[i];
         repeat (bt) @(posedge pclk);
      end
   endtask : send
endmodule : usa_slave_model

// *** testbench/testbench.sv ***
// Self-checking bench: APB tasks, auto-baud runs and synchronous transmit.
// Assumes the serial unit, its package and the far side model.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import usa_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   usa_apb_req_t req = '0;
   usa_apb_rsp_t rsp;
   usa_pins_t pins;
   logic line;
   logic pol = 1'b0;
   logic rx_wire;
   logic [31:0] q;
   logic e;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int bt [5] = '{160, 40, 40, 10, 4120};
   logic [2:0] md [5] = '{3'b000, 3'b001, 3'b010, 3'b111, 3'b001};
   logic [15:0] cnt [5] = '{16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0102};
   logic [7:0] offs [6] = '{OFF_RECEIVE_STATUS, OFF_BAUD_CONTROL, OFF_RATE_LOW, OFF_RATE_HIGH,
      OFF_TRANSMIT_DATA, OFF_RECEIVE_DATA};
   always #12.5 pclk = ~pclk;
   // The device wins the shared data wire while it drives it
   assign rx_wire = pins.rx_data_pin_oe ? pins.rx_data_pin_o : line;
   usa_serial_unit dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(req), .apb_rsp(rsp),
      .rx_data_pin_i(rx_wire), .pins(pins));
   usa_slave_model far_u (.pclk(pclk), .pins(pins), .pol(pol), .line(line));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (rsp.pready !== 1'b1) chk(32'h0, 32'h1);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
      apb(1'b0, a, 32'h0);
      chk(q & m, exp & m);
   endtask : rd
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   // Longest run is the last auto-baud case, 4120-cycle bits at the mid prescale, about 41200 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      logic [3:0] ctl;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [31:0] exp;
      int nb;
      int n;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (offs[i]) rd(offs[i], 32'h0);
      rd(OFF_TRANSMIT_STATUS, 32'h0, 32'h3f);
      apb(1'b1, 8'h1c, 32'hff);
      chk({31'h0, e}, 32'h1);
      rd(8'h1c, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, OFF_RATE_LOW, 32'ha5);
      rd(OFF_RATE_LOW, 32'ha5);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         ctl = {md[i][1], 1'b0, md[i][2], 1'b1};
         apb(1'b1, OFF_TRANSMIT_STATUS, {26'h0, md[i][0], 5'h0});
         apb(1'b1, OFF_BAUD_CONTROL, {28'h0, ctl});
         fork
            far_u.send(bt[i], md[i][2]);
            rd(OFF_BAUD_CONTROL, {26'h0, 2'b10, ctl});
         join
         rd(OFF_BAUD_CONTROL, {27'h0, 1'b1, ctl[3:1], 1'b0});
         rd(OFF_RATE_LOW, {24'h0, cnt[i][7:0]});
         rd(OFF_RATE_HIGH, {24'h0, cnt[i][15:8]});
         rd(OFF_RECEIVE_DATA, 32'h0);
         rd(OFF_BAUD_CONTROL, {28'h0, ctl[3:1], 1'b0});
      end
      $display("test auto-baud done");
      apb(1'b1, OFF_RATE_LOW, 32'h1);
      apb(1'b1, OFF_RATE_HIGH, 32'h0);
      apb(1'b1, OFF_RECEIVE_STATUS, 32'h1);
      for (int k = 0; k < 4; k++) begin
         nb = k[1] ? 9 : 8;
         d0 = 8'h96 ^ 8'(k);
         d1 = 8'h3c ^ 8'(k);
         apb(1'b1, OFF_BAUD_CONTROL, {29'h0, k[0], 2'b00});
         pol <= k[0];
         apb(1'b1, OFF_TRANSMIT_STATUS, {27'h0, 1'b1, k[1], 3'b111});
         far_u.clear();
         apb(1'b1, OFF_TRANSMIT_DATA, {24'h0, d0});
         apb(1'b1, OFF_TRANSMIT_DATA, {24'h0, d1});
         n = 0;
         while (far_u.n_bits < 2 * nb && n < 500) begin
            @(posedge pclk);
            n++;
         end
         repeat (20) @(posedge pclk);
         exp = k[1] ? {14'h0, 1'b1, d1, 1'b1, d0} : {16'h0, d1, d0};
         chk(far_u.got, exp);
         chk(32'(far_u.n_lead), 32'(2 * nb));
         chk({30'h0, pins.tx_clock_pin_o, pins.tx_clock_pin_oe}, {30'h0, k[0], 1'b1});
         chk({31'h0, pins.rx_data_pin_oe}, 32'h1);
         // Both empty flags set, high speed left clear, ninth bit set, nine-bit mode per test
         rd(OFF_TRANSMIT_STATUS, {24'h0, 3'b110, 1'b1, k[1], 3'b111});
      end
      $display("test transmit done");
      end_of_test();
   end
endmodule : testbench
